/* design/ast_pkg.sv */
// Purpose: Constants and types for the snooze-mode converter trigger block.
// Assumes: One 250 MHz clock; APB slave with 32-bit data.
// Notes:   Offsets are byte addresses; every register is one aligned word.
//
// Behaviour
// [RQ1] Timer counts slow clock, reload 59999, underflows
// [RQ2] Timer underflow is the converter hardware trigger
// [RQ3] Software sets select, one-shot, trigger-wait mode
// [RQ4] Channel zero is the only analog input
// [RQ5] Operation-enable bit arms the voltage comparator
// [RQ6] Count-start bit runs timer; timer irq masked
// [RQ7] Snooze-enable bit allows conversions during stop
// [RQ8] Trigger in stop starts conversion, CPU sleeps
// [RQ9] Conversion end writes result, raises end irq
// [RQ10] End irq wakes device; software clears snooze
// [RQ11] Software shifts result right six, stores it
// [RQ12] Software clears end flag and mask first
// [RQ13] Software keeps ten most recent results
// [RQ14] Software re-arms snooze and re-enters stop
// [RQ15] Trigger recurs about every four seconds
// [RQ16] Result holds 10-bit value left-justified
package ast_pkg;

  // ==========================================================================
  // Timing
  localparam int CLOCK_HZ        = 250_000_000;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int LOSC_HZ         = 15_000;
  localparam int LOSC_DIV_CYCLES = (CLOCK_HZ + LOSC_HZ / 2) / LOSC_HZ;
  localparam int CONV_TIME_NS    = 9_000;
  localparam int CONV_CYCLES     =
    (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);
  localparam int DIV_W = 15;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_MODE0        = 8'h00;
  localparam logic [7:0] ADDR_MODE2        = 8'h04;
  localparam logic [7:0] ADDR_RESULT       = 8'h08;
  localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_TIMER_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h18;
  localparam logic [7:0] ADDR_STATE        = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int BIT_OP_ENABLE   = 0;
  localparam int BIT_TIMING_LO   = 1;
  localparam int BIT_TIMING_HI   = 5;
  localparam int BIT_CHAN_MODE   = 6;
  localparam int BIT_SNOOZE      = 2;
  localparam int BIT_TIMER_START = 0;
  localparam int BIT_TIMER_RUN   = 1;
  localparam int BIT_IRQ_CONV    = 0;
  localparam int BIT_IRQ_TIMER   = 1;
  localparam int BIT_ST_WAIT     = 0;
  localparam int BIT_ST_BUSY     = 1;
  localparam int BIT_ST_SNOOZE   = 2;
  localparam int BIT_ST_STOP     = 3;
  localparam int RESULT_SHIFT    = 6;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] TIMER_RELOAD_RST = 16'hEA5F;
  localparam logic [1:0]  IRQ_MASK_RST     = 2'h3;
  localparam logic [4:0]  TIMING_RST       = 5'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} ast_conv_state_t;

  typedef struct packed {
    ast_conv_state_t state;
    logic [11:0]     convCount;
    logic            opEnable;
    logic            chanMode;
    logic [4:0]      convTiming;
    logic            snoozeEnable;
    logic            timerStart;
    logic [15:0]     timerReload;
    logic [15:0]     result;
    logic [1:0]      status;
    logic [1:0]      mask;
    logic            snoozeActive;
    logic            cpuWake;
    logic            irq;
    logic            sampleHold;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } ast_regs_t;

endpackage : ast_pkg

/* design/ast_sync.sv */
// Purpose: Two-stage synchroniser for levels from outside the clock domain.
// Assumes: Input is a level that may change at any time.
// Notes:   First stage feeds the second stage only.
`timescale 1ns/10ps
module ast_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,   // System clock
  input  wire logic         reset,   // Synchronous reset, active high
  input  wire logic [W-1:0] async,   // Level from outside the domain
  output logic      [W-1:0] synced   // Synchronised level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ast_sync_t;

  ast_sync_t cur;
  ast_sync_t next_cur;

  always_comb begin
    next_cur.s1 = async;
    next_cur.s2 = cur.s1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign synced = cur.s2;

endmodule : ast_sync

/* design/ast_reload_timer.sv */
// Purpose: Down counter that reloads and pulses on underflow.
// Assumes: tick is a one-cycle enable; run low holds the reload value.
// Notes:   Period is reloadValue + 1 ticks; underflow is registered.
`timescale 1ns/10ps
module ast_reload_timer #(
  parameter int W = 16
) (
  input  wire logic         clock,       // System clock
  input  wire logic         reset,       // Synchronous reset, active high
  input  wire logic         run,         // Count while high
  input  wire logic         tick,        // Count enable pulse
  input  wire logic [W-1:0] reloadValue, // Value loaded on underflow
  output logic              underflow,   // One-cycle underflow pulse
  output logic      [W-1:0] count        // Present count
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         uf;
  } ast_tmr_t;

  ast_tmr_t cur;
  ast_tmr_t next_cur;

  always_comb begin
    next_cur    = cur;
    next_cur.uf = 1'b0;
    if (!run) begin
      next_cur.count = reloadValue;
    end else if (tick) begin
      if (cur.count == '0) begin
        next_cur.count = reloadValue;
        next_cur.uf    = 1'b1;
      end else begin
        next_cur.count = cur.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign underflow = cur.uf;
  assign count     = cur.count;

endmodule : ast_reload_timer

/* design/ast_snooze_trigger.sv */
// Purpose: Interval timer, event link and snooze-capable converter control.
// Assumes: Analog front end delivers a 10-bit sample on this clock.
// Notes:   stopMode comes from the power controller and is synchronised.
`timescale 1ns/10ps
module ast_snooze_trigger
  import ast_pkg::*;
#(
  parameter int LOSC_DIV = LOSC_DIV_CYCLES
) (
  input  wire logic        clock,        // 250 MHz system clock
  input  wire logic        reset,        // Synchronous reset, active high
  input  wire logic [7:0]  paddr,        // APB address
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        stopMode,     // Device in stop mode
  input  wire logic [9:0]  sampleData,   // Converted analog value
  output logic             sampleHold,   // Conversion start pulse
  output logic             snoozeActive, // Converter runs in snooze
  output logic             cpuWake,      // Wake request pulse
  output logic             irq           // Level interrupt
);

  ast_regs_t          cur;
  ast_regs_t          next_cur;
  logic               stopSync;
  logic               oscTick;
  logic               timerUnderflow;
  logic [15:0]        timerCount;
  logic               trigger;
  logic               accessEdge;
  logic               convDone;
  logic [31:0]        readMux;
  logic               mapped;

  // ==========================================================================
  // Stop-mode input and slow clock
  ast_sync #(
    .W (1)
  ) uStopSync (
    .clock  (clock),
    .reset  (reset),
    .async  (stopMode),
    .synced (stopSync)
  );

  // Slow oscillator enable pulse
  ast_reload_timer #(
    .W (DIV_W)
  ) uOscDiv (
    .clock       (clock),
    .reset       (reset),
    .run         (1'b1),
    .tick        (1'b1),
    .reloadValue (DIV_W'(LOSC_DIV - 1)),
    .underflow   (oscTick),
    .count       ()
  );

  // [RQ1] [RQ15] interval timer reload
  ast_reload_timer #(
    .W (16)
  ) uIntervalTimer (
    .clock       (clock),
    .reset       (reset),
    .run         (cur.timerStart),
    .tick        (oscTick),
    .reloadValue (cur.timerReload),
    .underflow   (timerUnderflow),
    .count       (timerCount)
  );

  // [RQ2] event link routing
  assign trigger = timerUnderflow;

  // ==========================================================================
  // Register read decode
  always_comb begin
    readMux = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      ADDR_MODE0: begin
        readMux[BIT_OP_ENABLE]               = cur.opEnable;
        readMux[BIT_TIMING_HI:BIT_TIMING_LO] = cur.convTiming;
        readMux[BIT_CHAN_MODE]               = cur.chanMode;
      end
      ADDR_MODE2: begin
        readMux[BIT_SNOOZE] = cur.snoozeEnable;
      end
      ADDR_RESULT: begin
        readMux[15:0] = cur.result;
      end
      ADDR_TIMER_CTRL: begin
        readMux[BIT_TIMER_START] = cur.timerStart;
        readMux[BIT_TIMER_RUN]   = cur.timerStart;
        readMux[31:16]           = timerCount;
      end
      ADDR_TIMER_RELOAD: begin
        readMux[15:0] = cur.timerReload;
      end
      ADDR_IRQ_STATUS: begin
        readMux[1:0] = cur.status;
      end
      ADDR_IRQ_MASK: begin
        readMux[1:0] = cur.mask;
      end
      ADDR_STATE: begin
        readMux[BIT_ST_WAIT]   = (cur.state == ST_WAIT);
        readMux[BIT_ST_BUSY]   = (cur.state == ST_CONV);
        readMux[BIT_ST_SNOOZE] = cur.snoozeActive;
        readMux[BIT_ST_STOP]   = stopSync;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign accessEdge = psel && penable && cur.pready;
  assign convDone   = (cur.state == ST_CONV) && (cur.convCount == 12'h000);

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_cur            = cur;
    next_cur.cpuWake    = 1'b0;
    next_cur.sampleHold = 1'b0;

    // APB: answer prepared in setup, ready in access phase
    if (psel && !penable) begin
      next_cur.pready  = 1'b1;
      next_cur.prdata  = readMux;
      next_cur.pslverr = !mapped;
    end else begin
      next_cur.pready  = 1'b0;
      next_cur.pslverr = 1'b0;
    end

    if (accessEdge && pwrite) begin
      case (paddr)
        ADDR_MODE0: begin
          // [RQ5] operation enable write
          next_cur.opEnable   = pwdata[BIT_OP_ENABLE];
          next_cur.convTiming = pwdata[BIT_TIMING_HI:BIT_TIMING_LO];
          next_cur.chanMode   = pwdata[BIT_CHAN_MODE];
        end
        ADDR_MODE2: begin
          // [RQ7] [RQ10] snooze enable set and clear
          next_cur.snoozeEnable = pwdata[BIT_SNOOZE];
        end
        ADDR_TIMER_CTRL: begin
          // [RQ6] timer count start
          next_cur.timerStart = pwdata[BIT_TIMER_START];
        end
        ADDR_TIMER_RELOAD: begin
          next_cur.timerReload = pwdata[15:0];
        end
        ADDR_IRQ_MASK: begin
          next_cur.mask = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Read clears only the bits that were reported
    if (accessEdge && !pwrite && paddr == ADDR_IRQ_STATUS) begin
      next_cur.status = cur.status & ~cur.prdata[1:0];
    end

    // Converter sequencer
    case (cur.state)
      ST_IDLE: begin
        if (cur.opEnable) begin
          next_cur.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // [RQ8] trigger accepted awake, or in stop with snooze
        if (trigger && (!stopSync || cur.snoozeEnable)) begin
          next_cur.state        = ST_CONV;
          next_cur.convCount    = CONV_LAST;
          next_cur.sampleHold   = 1'b1;
          next_cur.snoozeActive = stopSync;
        end
      end
      ST_CONV: begin
        if (cur.convCount != 12'h000) begin
          next_cur.convCount = cur.convCount - 12'h001;
        end else begin
          // [RQ9] [RQ16] result left-justified
          next_cur.result = {sampleData, 6'h00};
          next_cur.state  = ST_WAIT;
          // [RQ10] wake from snooze
          if (cur.snoozeActive) begin
            next_cur.cpuWake      = 1'b1;
            next_cur.snoozeActive = 1'b0;
          end
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    // [RQ5] comparator off drops any conversion
    if (!cur.opEnable) begin
      next_cur.state        = ST_IDLE;
      next_cur.snoozeActive = 1'b0;
    end

    // [RQ9] event sets win over read clear
    if (convDone) begin
      next_cur.status[BIT_IRQ_CONV] = 1'b1;
    end
    if (timerUnderflow) begin
      next_cur.status[BIT_IRQ_TIMER] = 1'b1;
    end

    // [RQ6] masked bits stay off the interrupt line
    next_cur.irq = |(next_cur.status & ~next_cur.mask);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cur             <= '0;
      cur.state       <= ST_IDLE;
      cur.convTiming  <= TIMING_RST;
      cur.timerReload <= TIMER_RELOAD_RST;
      cur.mask        <= IRQ_MASK_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata       = cur.prdata;
  assign pready       = cur.pready;
  assign pslverr      = cur.pslverr;
  assign sampleHold   = cur.sampleHold;
  assign snoozeActive = cur.snoozeActive;
  assign cpuWake      = cur.cpuWake;
  assign irq          = cur.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_snooze_trig;
    cur.state == ST_WAIT && trigger && stopSync && cur.snoozeEnable
      && cur.opEnable;
  endsequence

  sequence s_awake_trig;
    cur.state == ST_WAIT && trigger && !stopSync && cur.opEnable;
  endsequence

  sequence s_conv_done;
    cur.state == ST_CONV && cur.convCount == 12'h000 && cur.opEnable;
  endsequence

  property p_uf_on_tick;
    timerUnderflow |-> $past(oscTick);
  endproperty
  a_uf_on_tick: assert property (p_uf_on_tick) // [RQ1]
    else $error("timer underflow without slow clock tick");

  property p_link_trigger;
    s_awake_trig |=> cur.state == ST_CONV && sampleHold && !snoozeActive;
  endproperty
  a_link_trigger: assert property (p_link_trigger) // [RQ2]
    else $error("underflow did not start a conversion");

  property p_disabled_idle;
    !cur.opEnable |=> cur.state == ST_IDLE && !snoozeActive;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // [RQ5]
    else $error("converter active while disabled");

  property p_timer_halted;
    !cur.timerStart && $past(!cur.timerStart) |-> !timerUnderflow;
  endproperty
  a_timer_halted: assert property (p_timer_halted) // [RQ6]
    else $error("timer underflow while stopped");

  property p_snooze_needs_enable;
    $rose(snoozeActive) |-> $past(cur.snoozeEnable) && $past(stopSync);
  endproperty
  a_snooze_needs_enable: assert property (p_snooze_needs_enable) // [RQ7]
    else $error("snooze entered without enable");

  property p_stop_no_snooze;
    cur.state == ST_WAIT && stopSync && !cur.snoozeEnable
      |=> cur.state != ST_CONV;
  endproperty
  a_stop_no_snooze: assert property (p_stop_no_snooze) // [RQ7]
    else $error("conversion in stop without snooze");

  property p_snooze_conv;
    s_snooze_trig |=> cur.state == ST_CONV && snoozeActive && !cpuWake;
  endproperty
  a_snooze_conv: assert property (p_snooze_conv) // [RQ8]
    else $error("snooze trigger mishandled");

  property p_conv_result;
    s_conv_done |=> cur.status[BIT_IRQ_CONV]
      && cur.result == {$past(sampleData), 6'h00};
  endproperty
  a_conv_result: assert property (p_conv_result) // [RQ9]
    else $error("result or end flag not written");

  // Cycles since the start pulse, for the conversion-time check
  logic [11:0] holdAge;
  always_ff @(posedge clock) begin
    holdAge <= (reset || sampleHold) ? {11'h000, !reset} : holdAge + 12'h001;
  end

  property p_conv_length;
    convDone |-> holdAge == CONV_LAST;
  endproperty
  a_conv_length: assert property (p_conv_length) // [RQ9]
    else $error("conversion time wrong");

  property p_wake;
    s_conv_done ##0 snoozeActive |=> cpuWake && !snoozeActive;
  endproperty
  a_wake: assert property (p_wake) // [RQ10]
    else $error("no wake after snooze conversion");

  property p_irq_level;
    |(cur.status & ~cur.mask) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) // [RQ9]
    else $error("interrupt not raised for unmasked flag");

endmodule : ast_snooze_trigger

/* tb/ast_afe_model.sv */
// Purpose: Analog front end model feeding the converter block.
// Assumes: A new sample is taken on each conversion start pulse.
// Notes:   Sample k is 0x155 + k * 0xB7, modulo 10 bits.
`timescale 1ns/10ps
module ast_afe_model (
  input  wire logic       clock,      // System clock
  input  wire logic       reset,      // Synchronous reset, active high
  input  wire logic       sampleHold, // Conversion start pulse
  output logic      [9:0] sampleData  // Held analog sample
);
  logic [9:0] nextValue;

  // ==========================================================================
  // Sampling
  // single channel source
  always_ff @(posedge clock) begin
    if (reset) begin
      nextValue  <= 10'h155;
      sampleData <= 10'h2AA;
    end else if (sampleHold) begin
      sampleData <= nextValue;
      nextValue  <= nextValue + 10'h0B7;
    end
  end
endmodule : ast_afe_model

/* tb/test_ast_snooze_trigger.sv */
// Purpose: Self-checking bench for the snooze converter trigger block.
// Assumes: APB master with zero wait state slave; small timer divider.
// Notes:   Divider 4; reload 3 for the timer test, then 599, so that a
//          trigger comes 2400 cycles apart, longer than one conversion.
`timescale 1ns/10ps
module test_ast_snooze_trigger;
  import ast_pkg::*;

  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stopMode = 1'b0;
  logic [9:0]  sampleData;
  logic        sampleHold;
  logic        snoozeActive;
  logic        cpuWake;
  logic        irq;
  int          n_errors = 0;
  int          checks = 0;
  int          nHold = 0;
  int          bufIdx = 0;
  logic [15:0] resBuf [10];

  always #2 clock = ~clock;

  ast_snooze_trigger #(.LOSC_DIV(4)) dut (
    .clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
    .sampleData(sampleData), .sampleHold(sampleHold),
    .snoozeActive(snoozeActive), .cpuWake(cpuWake), .irq(irq));

  ast_afe_model afe (.clock(clock), .reset(reset), .sampleHold(sampleHold),
    .sampleData(sampleData));

  always @(posedge clock) begin
    if (reset) nHold <= 0;
    else if (sampleHold === 1'b1) nHold <= nHold + 1;
  end

  // ==========================================================================
  // Helpers
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, 1);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic err;
    apb(1'b0, a, 32'h0, d, err);
  endtask : rd

  task automatic quiet(input int cyc, output logic seen);
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clock);
      seen = seen | (sampleHold !== 1'b0);
    end
  endtask : quiet

  // One full conversion, checked from start pulse to interrupt clear
  task automatic conv(input logic snz);
    int          n;
    int          k;
    logic        woke;
    logic [31:0] d;
    logic [9:0]  e;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sampleHold !== 1'b1 && n < 3000);
    k = nHold;
    e = 10'h155 + 10'(k) * 10'h0B7;
    chk(n < 3000, 1);
    chk(snoozeActive, snz);
    n = 0;
    woke = 1'b0;
    do begin
      @(posedge clock);
      n++;
      if (cpuWake === 1'b1 && n == CONV_CYCLES) woke = 1'b1;
    end while (irq !== 1'b1 && n < 3000);
    chk(n, CONV_CYCLES);
    chk(woke, snz);
    chk(snoozeActive, 0);
    rd(ADDR_RESULT, d);
    chk(d, {16'h0, e, 6'h00});
    resBuf[bufIdx] = d[15:0] >> 6;
    chk(resBuf[bufIdx], {6'h00, e});
    bufIdx = (bufIdx + 1) % 10;
    chk(bufIdx < 10, 1);
    rd(ADDR_IRQ_STATUS, d);
    chk(d[BIT_IRQ_CONV], 1);
    repeat (2) @(posedge clock);
    chk(irq, 0);
  endtask : conv

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0]  a [8];
    logic [31:0] x [8];
    logic [31:0] d;
    logic        err;
    a = '{ADDR_MODE0, ADDR_MODE2, ADDR_RESULT, ADDR_TIMER_CTRL,
          ADDR_TIMER_RELOAD, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_STATE};
    x = '{32'h0, 32'h0, 32'h0, {TIMER_RELOAD_RST, 16'h0000}, 32'h0000EA5F,
          32'h0, 32'h3, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      chk(d, x[i]);
    end
    apb(1'b0, 8'h20, 32'h0, d, err);
    chk(err, 1);
    chk(d, 0);
  endtask : t_reset

  task automatic t_timer;
    logic [31:0] d;
    logic        seen;
    wr(ADDR_TIMER_RELOAD, 32'h3);
    wr(ADDR_TIMER_CTRL, 32'h1);
    seen = 1'b0;
    repeat (40) begin
      @(posedge clock);
      seen = seen | (irq !== 1'b0);
    end
    chk(seen, 0);
    rd(ADDR_IRQ_STATUS, d);
    chk(d[BIT_IRQ_TIMER], 1);
    rd(ADDR_TIMER_CTRL, d);
    chk(d[BIT_TIMER_RUN], 1);
    chk(d[31:16] <= 16'h0003, 1);
  endtask : t_timer

  task automatic t_norm;
    logic [31:0] d;
    // clear flag and unmask before arming
    wr(ADDR_IRQ_MASK, 32'h2);
    rd(ADDR_IRQ_STATUS, d);
    // Trigger period longer than a conversion, so none overlaps
    wr(ADDR_TIMER_RELOAD, 32'h257);
    // select mode, timing field, operation enable
    wr(ADDR_MODE0, 32'h19);
    rd(ADDR_MODE0, d);
    chk(d, 32'h19);
    conv(1'b0);
  endtask : t_norm

  task automatic t_refuse;
    logic [31:0] d;
    logic        seen;
    wr(ADDR_MODE0, 32'h0);
    quiet(2500, seen);
    chk(seen, 0);
    stopMode <= 1'b1;
    wr(ADDR_MODE0, 32'h1);
    quiet(2500, seen);
    chk(seen, 0);
    rd(ADDR_STATE, d);
    chk(d, (32'h1 << BIT_ST_WAIT) | (32'h1 << BIT_ST_STOP));
  endtask : t_refuse

  task automatic t_snooze;
    logic [31:0] d;
    wr(ADDR_MODE2, 32'h4);
    rd(ADDR_MODE2, d);
    chk(d[BIT_SNOOZE], 1);
    conv(1'b1);
    // software leaves snooze after the wake
    wr(ADDR_MODE2, 32'h0);
    stopMode <= 1'b0;
    // re-arm and re-enter stop for the next trigger
    wr(ADDR_MODE2, 32'h4);
    stopMode <= 1'b1;
    conv(1'b1);
  endtask : t_snooze

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_timer;
    t_norm;
    t_refuse;
    t_snooze;
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    end_sim;
  end
endmodule : test_ast_snooze_trigger
